/* File: bpsc_board.sv */
`timescale 1ns/1ps
`default_nettype none
module bpsc_board (
  // jumper and fixed resistor settings
  input  wire logic [30:0] setting,
  // strap pins toward the bridge
  output logic [30:0]      cfg_strap_bus
);
  // resistors hold levels steady; bit 18 picks who arbitrates
  assign cfg_strap_bus = setting;
endmodule
`default_nettype wire

/* File: bpsc_pkg.sv */
package bpsc_pkg;
  // strap bus layout
  localparam int STRAP_W   = 31;
  localparam int B_ORDER   = 30;
  localparam int B_UARTCLK = 29;
  localparam int B_CFGHOLD = 28;
  localparam int B_CFGMASK = 27;
  localparam int B_CPUHOLD = 26;
  localparam int B_SDRBUF  = 25;
  localparam int B_AOACK   = 24;
  localparam int B_PUST_HI = 23;
  localparam int B_PUST_LO = 20;
  localparam int B_CLASS   = 19;
  localparam int B_PCIARB  = 18;
  localparam int B_CPUARB  = 17;
  localparam int B_BASE_LO = 15;
  localparam int B_RAT_LO  = 12;
  localparam int B_P0W_LO  = 10;
  localparam int B_VEC0    = 9;
  localparam int B_P1W_LO  = 7;
  localparam int B_VEC1    = 6;
  localparam int B_P2W_LO  = 4;
  localparam int B_VEC2    = 3;
  localparam int B_P3W_LO  = 1;
  localparam int B_VEC3    = 0;
  // settle time of the pin synchroniser
  localparam int SYNC_STAGES = 2;
  // register offsets
  localparam logic [7:0] REG_STRAP  = 8'h00;
  localparam logic [7:0] REG_CTRL   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_ROUTE  = 8'h0C;
  // control register fields
  localparam int C_CFGHOLD = 0;
  localparam int C_CPUHOLD = 1;
  localparam int C_ORDER   = 2;
  localparam int C_VEC0    = 3;
  localparam int C_VEC1    = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  // clock ratio codes
  localparam logic [2:0] RAT_3_2 = 3'h1;
  localparam logic [2:0] RAT_2_1 = 3'h2;
  localparam logic [2:0] RAT_5_2 = 3'h3;
  localparam logic [2:0] RAT_1_1 = 3'h4;
  localparam logic [2:0] RAT_3_1 = 3'h6;
  // register group base per strap code
  localparam logic [31:0] BASE_00 = 32'hFEFF0000;
  localparam logic [31:0] BASE_01 = 32'hFEFE0000;
  localparam logic [31:0] BASE_10 = 32'hFEFD0000;
  localparam logic [31:0] BASE_11 = 32'hFEFC0000;
  // reset vector window
  localparam logic [31:0] VEC_LO = 32'hFFF00000;
  // class codes reported in configuration space
  localparam logic [23:0] CLASS_BRIDGE = 24'h068000;
  localparam logic [23:0] CLASS_IOP    = 24'h0E0001;

  typedef enum logic [1:0] {BANK_NONE, BANK_A, BANK_B} bpsc_bank_e;
  typedef enum {ST_WAIT, ST_LOAD, ST_RUN} bpsc_state_e;
  typedef enum {ARB_IDLE, ARB_CPU, ARB_BRG} bpsc_arb_e;

  // captured configuration
  typedef struct packed {
    logic        uart_ext_clk;
    logic        cfg_space_mask;
    logic        sdram_ext_buffer_flag;
    logic        unmapped_addr_only_ack;
    logic [3:0]  power_up_status;
    logic        class_iop;
    logic        pci_arb_en;
    logic        cpu_arb_en;
    logic [1:0]  base_code;
    logic [2:0]  clk_ratio;
    logic [1:0]  port0_data_width;
    logic [1:0]  port1_data_width;
    logic [1:0]  port2_data_width;
    logic [1:0]  port3_data_width;
    logic        vec_en2;
    logic        vec_en3;
  } bpsc_cfg_s;
endpackage

/* File: bpsc_strap_cfg.sv */
// Behaviour
// - sample strap pins 30..0 just after power-up reset release for configuration
// - bit 30 high selects legacy 16-bit data ordering, low native
// - configuration holdoff retries every external config access until cleared
// - bit 27 low leaves all config registers visible, none masked
// - bit 26 holds processor in reset until software releases it
// - bit 25 low means no external SDRAM register buffers assumed
// - bit 24 high acknowledges unmapped address-only processor cycles
// - bits 23..20 captured as status bits 3..0, software readable
// - bit 19 low reports bridge class, high reports I/O processor
// - bit 18 enables internal PCI arbiter; board passes it through from setting
// - bit 17 high enables internal processor-bus arbiter
// - bits 16..15 pick register group base; 00 is FEFF0000
// - bits 14..12 encode clock ratio; 000, 101, 111 reserved
// - bits 11..10 set channel 0 width; 01 is 16-bit
// - bit 9 enables channel 0 as reset vector source
// - bits 8..7 set channel 1 width; 11 is 16-bit legacy
// - bit 6 makes channel 1 vector source when channel 0 disabled
// - bits 3 and 0 low keep channels 2, 3 off vectors
// - processor-bus arbiter grants between processor and bridge master
// - vector range FFF00000..FFFFFFFF goes to bank A if channel 0 enabled, else B if channel 1, else none; outside it none
`timescale 1ns/1ps
`default_nettype none
module bpsc_strap_cfg
  import bpsc_pkg::*;
(
  // clock, reset, enable
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // strap pins
  input  wire logic [30:0]  cfg_strap_bus,
  // register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [31:0]       reg_rdata,
  // pci configuration access gate
  input  wire logic         pci_cfg_req,
  output logic              pci_cfg_retry,
  output logic              pci_cfg_accept,
  // processor address-only cycles
  input  wire logic         cpu_addr_only,
  input  wire logic         cpu_addr_hit,
  output logic              cpu_ao_ack,
  // processor bus arbitration
  input  wire logic         cpu_bus_request,
  input  wire logic         brg_bus_request,
  output logic              cpu_bus_grant,
  output logic              brg_bus_grant,
  // reset vector routing
  input  wire logic [31:0]  vec_addr,
  input  wire logic         vec_valid,
  output bpsc_bank_e        vec_bank,
  // configuration outputs
  output logic              cfg_loaded,
  output logic              cpu_hold_reset,
  output logic              legacy_data_order_en,
  output logic              cfg_space_mask,
  output logic              sdram_ext_buffer_flag,
  output logic              uart_ext_clk_sel,
  output logic [23:0]       pci_class_code,
  output logic              pci_arb_en,
  output logic              cpu_arb_en,
  output logic [31:0]       bridge_ctrl_group,
  output logic [2:0]        clk_ratio,
  output logic              clk_ratio_ok,
  output logic [1:0]        port0_data_width,
  output logic [1:0]        port1_data_width
);

  // true for a defined processor-to-pci ratio code
  function automatic logic ratio_ok(input logic [2:0] c);
    case (c)
      RAT_3_2, RAT_2_1, RAT_5_2, RAT_1_1, RAT_3_1: ratio_ok = 1'b1;
      default:                                    ratio_ok = 1'b0;
    endcase
  endfunction

  // bank that serves the reset vector
  function automatic bpsc_bank_e vec_route(input logic en0,
                                           input logic en1);
    if (en0) begin
      vec_route = BANK_A;
    end else if (en1) begin
      vec_route = BANK_B;
    end else begin
      vec_route = BANK_NONE;
    end
  endfunction

  // base address of the register group
  function automatic logic [31:0] base_of(input logic [1:0] c);
    case (c)
      2'h0:    base_of = BASE_00;
      2'h1:    base_of = BASE_01;
      2'h2:    base_of = BASE_10;
      default: base_of = BASE_11;
    endcase
  endfunction

  // pin synchroniser; first stage is read only by the second
  logic [30:0] sync1_q;
  logic [30:0] sync2_q;
  logic        req1_q;
  logic        req2_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      req1_q  <= 1'b0;
      req2_q  <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= cfg_strap_bus;
      sync2_q <= sync1_q;
      req1_q  <= cpu_bus_request;
      req2_q  <= req1_q;
    end
  end

  // capture sequencer and captured configuration
  bpsc_state_e st_q, st_d;
  logic [1:0]  wait_q, wait_d;
  logic [30:0] raw_q, raw_d;
  bpsc_cfg_s   cfg_q, cfg_d;
  logic [4:0]  ctrl_q, ctrl_d;

  // decode of the register port
  logic wr_ctrl;
  assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);

  // waiting for the synchroniser to fill avoids latching stale zeros
  always_comb begin
    st_d   = st_q;
    wait_d = wait_q;
    raw_d  = raw_q;
    cfg_d  = cfg_q;
    ctrl_d = ctrl_q;
    case (st_q)
      ST_WAIT: begin
        if (wait_q == 2'(SYNC_STAGES - 1)) begin
          st_d = ST_LOAD;
        end else begin
          wait_d = wait_q + 2'h1;
        end
      end
      ST_LOAD: begin
        raw_d = sync2_q;
        cfg_d.uart_ext_clk = sync2_q[B_UARTCLK];
        cfg_d.cfg_space_mask = sync2_q[B_CFGMASK];
        cfg_d.sdram_ext_buffer_flag = sync2_q[B_SDRBUF];
        cfg_d.unmapped_addr_only_ack = sync2_q[B_AOACK];
        cfg_d.power_up_status = sync2_q[B_PUST_HI:B_PUST_LO];
        cfg_d.class_iop = sync2_q[B_CLASS];
        cfg_d.pci_arb_en = sync2_q[B_PCIARB];
        cfg_d.cpu_arb_en = sync2_q[B_CPUARB];
        cfg_d.base_code = sync2_q[B_BASE_LO+1:B_BASE_LO];
        cfg_d.clk_ratio = sync2_q[B_RAT_LO+2:B_RAT_LO];
        cfg_d.port0_data_width = sync2_q[B_P0W_LO+1:B_P0W_LO];
        cfg_d.port1_data_width = sync2_q[B_P1W_LO+1:B_P1W_LO];
        cfg_d.port2_data_width = sync2_q[B_P2W_LO+1:B_P2W_LO];
        cfg_d.port3_data_width = sync2_q[B_P3W_LO+1:B_P3W_LO];
        // channels 2 and 3 vector enables
        cfg_d.vec_en2 = sync2_q[B_VEC2];
        cfg_d.vec_en3 = sync2_q[B_VEC3];
        ctrl_d[C_CFGHOLD] = sync2_q[B_CFGHOLD];
        ctrl_d[C_CPUHOLD] = sync2_q[B_CPUHOLD];
        ctrl_d[C_ORDER] = sync2_q[B_ORDER];
        ctrl_d[C_VEC0] = sync2_q[B_VEC0];
        ctrl_d[C_VEC1] = sync2_q[B_VEC1];
        st_d = ST_RUN;
      end
      ST_RUN: begin
        if (wr_ctrl) begin
          ctrl_d = reg_wdata[4:0];
        end
      end
      default: begin
        st_d = ST_WAIT;
      end
    endcase
  end

  // capture registers; state only moves with the clock enable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= ST_WAIT;
      wait_q <= 2'h0;
      raw_q  <= '0;
      cfg_q  <= '0;
      ctrl_q <= CTRL_RST;
    end else if (clk_en) begin
      st_q   <= st_d;
      wait_q <= wait_d;
      raw_q  <= raw_d;
      cfg_q  <= cfg_d;
      ctrl_q <= ctrl_d;
    end
  end

  // processor-bus arbiter
  bpsc_arb_e arb_q, arb_d;
  logic      cpu_ok;
  logic      arb_on;

  // a processor held in reset must not own the bus
  assign cpu_ok = req2_q && !cpu_hold_reset;
  assign arb_on = (st_q == ST_RUN) && cfg_q.cpu_arb_en;

  always_comb begin
    arb_d = arb_q;
    case (arb_q)
      ARB_IDLE: begin
        if (cpu_ok) begin
          arb_d = ARB_CPU;
        end else if (brg_bus_request) begin
          arb_d = ARB_BRG;
        end
      end
      ARB_CPU: begin
        // hand over on release so neither side starves
        if (!cpu_ok) begin
          arb_d = brg_bus_request ? ARB_BRG : ARB_IDLE;
        end
      end
      ARB_BRG: begin
        if (!brg_bus_request) begin
          arb_d = cpu_ok ? ARB_CPU : ARB_IDLE;
        end
      end
      default: begin
        arb_d = ARB_IDLE;
      end
    endcase
    if (!arb_on) begin
      arb_d = ARB_IDLE;
    end
  end

  // arbiter state; no parking, so an idle bus has no owner
  // limitation: a lone bridge requester pays one edge before its grant, the processor three
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      arb_q <= ARB_IDLE;
    end else if (clk_en) begin
      arb_q <= arb_d;
    end
  end

  // grants come straight from the state flops
  assign cpu_bus_grant = (arb_q == ARB_CPU);
  assign brg_bus_grant = (arb_q == ARB_BRG);

  // vector routing and register read data
  bpsc_bank_e  bank_q, bank_d;
  logic [31:0] rdata_q, rdata_d;

  always_comb begin
    bank_d = BANK_NONE;
    // window runs to the top of the space, so one compare suffices
    if (vec_valid && (vec_addr >= VEC_LO) && (st_q == ST_RUN)) begin
      bank_d = vec_route(ctrl_q[C_VEC0], ctrl_q[C_VEC1]);
    end
  end

  // read data stands only in the cycle after the strobe
  always_comb begin
    rdata_d = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        REG_STRAP: begin
          rdata_d = {1'b0, raw_q};
        end
        REG_CTRL: begin
          rdata_d = {27'h0, ctrl_q};
        end
        REG_STATUS: begin
          rdata_d = {20'h0, cfg_loaded, clk_ratio_ok, cfg_q.clk_ratio,
                     cfg_q.class_iop, cfg_q.base_code,
                     cfg_q.power_up_status};
        end
        REG_ROUTE: begin
          rdata_d = {24'h0, cfg_q.vec_en3, cfg_q.vec_en2,
                     cfg_q.port3_data_width, cfg_q.port2_data_width,
                     vec_route(ctrl_q[C_VEC0], ctrl_q[C_VEC1])};
        end
        default: begin
          rdata_d = 32'h00000000;
        end
      endcase
    end
  end

  // routing and read data registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bank_q  <= BANK_NONE;
      rdata_q <= 32'h00000000;
    end else if (clk_en) begin
      bank_q  <= bank_d;
      rdata_q <= rdata_d;
    end
  end

  // registered so the bank decode sees a glitch-free select
  assign vec_bank  = bank_q;
  assign reg_rdata = rdata_q;

  // configuration outputs
  assign cfg_loaded            = (st_q == ST_RUN);
  assign cpu_hold_reset        = !cfg_loaded || ctrl_q[C_CPUHOLD];
  assign legacy_data_order_en  = ctrl_q[C_ORDER];
  assign cfg_space_mask        = cfg_q.cfg_space_mask;
  assign sdram_ext_buffer_flag = cfg_q.sdram_ext_buffer_flag;
  assign uart_ext_clk_sel      = cfg_q.uart_ext_clk;
  assign pci_class_code = cfg_q.class_iop ? CLASS_IOP : CLASS_BRIDGE;
  // pci arbiter; off leaves arbitration to the baseboard
  assign pci_arb_en = cfg_q.pci_arb_en && cfg_loaded;
  // processor arbiter reported only once loaded
  assign cpu_arb_en = arb_on;
  assign bridge_ctrl_group = base_of(cfg_q.base_code);
  assign clk_ratio    = cfg_q.clk_ratio;
  assign clk_ratio_ok = ratio_ok(cfg_q.clk_ratio);
  assign port0_data_width = cfg_q.port0_data_width;
  assign port1_data_width = cfg_q.port1_data_width;

  // holdoff retries config access; retry also until load
  assign pci_cfg_retry  = pci_cfg_req && (!cfg_loaded || ctrl_q[C_CFGHOLD]);
  assign pci_cfg_accept = pci_cfg_req && !pci_cfg_retry;

  assign cpu_ao_ack = cpu_addr_only && !cpu_addr_hit && cfg_loaded &&
                      cfg_q.unmapped_addr_only_ack;

endmodule
`default_nettype wire

/* File: bpsc_strap_cfg_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module bpsc_strap_cfg_chk
  import bpsc_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // watched ports
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        pci_cfg_req,
  input wire logic        pci_cfg_retry,
  input wire logic        pci_cfg_accept,
  input wire logic        cpu_addr_only,
  input wire logic        cpu_addr_hit,
  input wire logic        cpu_ao_ack,
  input wire logic        cpu_bus_grant,
  input wire logic        brg_bus_grant,
  input wire logic        cpu_arb_en,
  input wire logic [31:0] vec_addr,
  input wire logic        vec_valid,
  input wire bpsc_bank_e  vec_bank,
  input wire logic        cfg_loaded,
  input wire logic        cpu_hold_reset,
  input wire logic [2:0]  clk_ratio,
  input wire logic        clk_ratio_ok
);
  // one clock domain, reset kills every check
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_gate_onehot: assert property (pci_cfg_req |-> pci_cfg_retry != pci_cfg_accept)
    else $error("config gate not one-hot");
  a_retry_unloaded: assert property (!cfg_loaded && pci_cfg_req |-> pci_cfg_retry)
    else $error("config access accepted before load");
  a_ao_ack_cause: assert property (cpu_ao_ack |-> cpu_addr_only && !cpu_addr_hit && cfg_loaded)
    else $error("address-only ack without cause");
  a_grant_single: assert property (!(cpu_bus_grant && brg_bus_grant))
    else $error("two bus owners");
  a_grant_enabled: assert property (cpu_bus_grant || brg_bus_grant |-> cpu_arb_en && cfg_loaded)
    else $error("grant with arbiter off");
  a_hold_till_load: assert property (!cfg_loaded || cpu_bus_grant |-> cpu_hold_reset == !cfg_loaded)
    else $error("processor hold wrong");
  a_loaded_kept: assert property (cfg_loaded |=> cfg_loaded)
    else $error("loaded flag dropped");
  a_ratio_ok: assert property (clk_ratio_ok == (clk_ratio inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6}))
    else $error("ratio valid flag wrong");
  a_vec_cause: assert property (vec_bank != BANK_NONE |-> $past(vec_valid) && $past(vec_addr) >= VEC_LO)
    else $error("vector bank without window hit");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule

bind bpsc_strap_cfg bpsc_strap_cfg_chk u_chk (
  .mclk, .rst_n, .reg_rd, .reg_rdata, .pci_cfg_req, .pci_cfg_retry, .pci_cfg_accept,
  .cpu_addr_only, .cpu_addr_hit, .cpu_ao_ack, .cpu_bus_grant, .brg_bus_grant, .cpu_arb_en,
  .vec_addr, .vec_valid, .vec_bank, .cfg_loaded, .cpu_hold_reset, .clk_ratio, .clk_ratio_ok
);
`default_nettype wire

/* File: bpsc_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import bpsc_pkg::*;
;
  logic        mclk, rst_n, reg_wr, reg_rd, pci_cfg_req, cpu_addr_only, cpu_addr_hit;
  logic        cpu_bus_request, brg_bus_request, vec_valid, rd_seen, ok, clk_en;
  logic        pci_cfg_retry, pci_cfg_accept, cpu_ao_ack, cpu_bus_grant, brg_bus_grant;
  logic        cfg_loaded, cpu_hold_reset, legacy_data_order_en, cfg_space_mask;
  logic        sdram_ext_buffer_flag, uart_ext_clk_sel, pci_arb_en, cpu_arb_en, clk_ratio_ok;
  logic [1:0]  port0_data_width, port1_data_width;
  logic [2:0]  clk_ratio;
  logic [7:0]  reg_addr;
  logic [9:0]  flags;
  logic [23:0] pci_class_code;
  logic [30:0] straps, cfg_strap_bus, s;
  logic [31:0] reg_wdata, reg_rdata, vec_addr, bridge_ctrl_group, ctl, e;
  logic [31:0] lf = 32'h00012116;
  logic [31:0] eq[$];
  logic [31:0] mq[$];
  logic [31:0] bases[4] = '{BASE_00, BASE_01, BASE_10, BASE_11};
  bpsc_bank_e  vec_bank, vb;
  int          fail_count = 0;
  int          check_count = 0;
  int          cyc = 0;

  // clock enable driven by the bench so a freeze can be tried
  bpsc_strap_cfg u_bpsc_strap_cfg (
    .mclk, .rst_n, .clk_en, .cfg_strap_bus, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pci_cfg_req, .pci_cfg_retry, .pci_cfg_accept, .cpu_addr_only, .cpu_addr_hit,
    .cpu_ao_ack, .cpu_bus_request, .brg_bus_request, .cpu_bus_grant, .brg_bus_grant, .vec_addr,
    .vec_valid, .vec_bank, .cfg_loaded, .cpu_hold_reset, .legacy_data_order_en, .cfg_space_mask,
    .sdram_ext_buffer_flag, .uart_ext_clk_sel, .pci_class_code, .pci_arb_en, .cpu_arb_en,
    .bridge_ctrl_group, .clk_ratio, .clk_ratio_ok, .port0_data_width, .port1_data_width
  );
  bpsc_board u_bpsc_board (.setting(straps), .cfg_strap_bus);

  // flag outputs gathered for one comparison
  assign flags = {legacy_data_order_en, cfg_space_mask, sdram_ext_buffer_flag, uart_ext_clk_sel,
                  pci_arb_en, cpu_arb_en, port0_data_width, port1_data_width};

  function automatic logic [31:0] nx(input logic [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // strobes stay up between calls so back-to-back transfers never
  // assign one strobe twice in a time step; bus_idle drops them
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic bus_idle;
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  // expected word and mask go to the queues, the monitor compares
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    eq.push_back(x);
    mq.push_back(m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  // straps only matter just after reset release, while the synchroniser fills
  task automatic boot(input logic [30:0] v);
    straps <= v;
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // read data stand only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rd_seen) chk(reg_rdata & mq.pop_front(), eq.pop_front());
    rd_seen <= reg_rd;
  end

  // hang guard, far above the few hundred cycles used
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    {reg_wr, reg_rd, pci_cfg_req, cpu_addr_only, cpu_addr_hit, rd_seen} = '0;
    {cpu_bus_request, brg_bus_request, vec_valid, rst_n} = '0;
    {reg_addr, reg_wdata, vec_addr, straps} = '0;
    clk_en = 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      s = lf[30:0];
      s[14:12] = i[2:0];
      s[16:15] = i[1:0];
      lf = nx(lf);
      boot(s);
      straps <= ~s;
      ctl = {27'h0, s[6], s[9], s[30], s[26], s[28]};
      ok = s[14:12] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
      e = 32'({s[30], s[27], s[25], s[29], s[18], s[17], s[11:10], s[8:7]});
      chk(32'(flags), e);
      chk(32'(pci_class_code), 32'(s[19] ? CLASS_IOP : CLASS_BRIDGE));
      chk(bridge_ctrl_group, bases[s[16:15]]);
      chk(32'({clk_ratio_ok, clk_ratio}), 32'({ok, s[14:12]}));
      wr(REG_STATUS, 32'hFFFFFFFF);
      rd(REG_STATUS, {20'h0, 1'b1, ok, s[14:12], s[19], s[16:15], s[23:20]}, '1);
      rd(REG_STRAP, {1'b0, s}, '1);
      rd(REG_ROUTE, {24'h0, s[0], s[3], s[2:1], s[5:4],
                     2'(s[9] ? BANK_A : s[6] ? BANK_B : BANK_NONE)}, '1);
      rd(REG_CTRL, ctl, '1);
      rd(8'h10, 32'h0, '1);
      bus_idle();
      pci_cfg_req <= 1'b1;
      cpu_addr_only <= 1'b1;
      @(posedge mclk);
      chk(32'({pci_cfg_retry, pci_cfg_accept, cpu_ao_ack, cpu_hold_reset}),
          32'({s[28], !s[28], s[24], s[26]}));
      wr(REG_CTRL, ctl & 32'h1C);
      bus_idle();
      cpu_addr_hit <= 1'b1;
      @(posedge mclk);
      chk(32'({pci_cfg_retry, pci_cfg_accept, cpu_ao_ack, cpu_hold_reset}), 32'h4);
      {pci_cfg_req, cpu_addr_only, cpu_addr_hit} <= 3'h0;
      for (int k = 0; k < 2; k++) begin
        vb = k ? BANK_NONE : s[9] ? BANK_A : s[6] ? BANK_B : BANK_NONE;
        vec_valid <= 1'b1;
        vec_addr <= k ? 32'hFFEFFFFF : {12'hFFF, lf[19:0]};
        @(posedge mclk);
        vec_valid <= 1'b0;
        #1;
        chk(32'(vec_bank), 32'(vb));
        @(posedge mclk);
      end
      // frozen clock enable: the request must not be granted yet
      clk_en <= 1'b0;
      brg_bus_request <= 1'b1;
      repeat (2) @(posedge mclk);
      chk(32'({cpu_bus_grant, brg_bus_grant}), 32'h0);
      clk_en <= 1'b1;
      repeat (2) @(posedge mclk);
      chk(32'({cpu_bus_grant, brg_bus_grant}), 32'(s[17]));
      brg_bus_request <= 1'b0;
      cpu_bus_request <= 1'b1;
      repeat (6) @(posedge mclk);
      chk(32'({cpu_bus_grant, brg_bus_grant}), 32'({s[17], 1'b0}));
      cpu_bus_request <= 1'b0;
      repeat (2) @(posedge mclk);
      $display("test %0d done", i);
    end
    stop_test();
  end
endmodule
`default_nettype wire
